//--- src/sfa_master.sv
// two-wire master for the biosensor register port, ahb-lite slave side
// assumes one target on the wires, pull-ups outside, scl returned as input
//
// Contract
// - master makes clock up to 400kHz
// - eight bits msb first, then ack
// - start/stop are sda edges while scl high
// - sda changes only while scl low
// - never stop in start's high pulse
// - repeated start keeps bus, new address
// - device address 0b1011110, bytes BC/BD
// - address lsb selects write or read
// - master acks reads, nacks last, stops
// - write: address, register, data bytes
// - read: write register, restart, read
// - master retries on missing acknowledge
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module sfa_master #(
	parameter int HALF_CYC  = sfa_pkg::SFA_HALF_CYC,  // scl half period
	parameter int RETRY_MAX = 3                       // nack retries
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic [31:0]            hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic                   scl_o,
	output logic                   scl_oe,
	input  wire logic              scl_i,
	output logic                   sda_o,
	output logic                   sda_oe,
	input  wire logic              sda_i
);
	import sfa_pkg::*;

	// synchronisers for the wire levels
	logic [1:0]  sda_sync_r;       // sda two-stage
	logic [1:0]  scl_sync_r;       // scl two-stage, observed only
	// ahb address phase capture
	logic        ahb_wr_r;         // pending write
	logic        ahb_rd_r;         // pending read
	logic [7:0]  ahb_off_r;        // pending offset
	// transfer control
	sfa_state_t  st_r;             // bit engine state
	sfa_phase_t  ph_r;             // which byte of the transfer
	logic [15:0] div_r;            // half-period counter
	logic [3:0]  bit_r;            // bit index in byte
	logic [7:0]  sh_r;             // shift register
	logic        busy_r;           // transfer running
	logic        is_rd_r;          // current command reads
	logic [7:0]  reg_r;            // register address
	logic [7:0]  wdat_r;           // write data byte
	logic [7:0]  rdat_r;           // last byte read
	logic        nack_r;           // last attempt failed
	logic [1:0]  retry_r;          // retries used
	logic        done_r;           // sticky completion
	logic [7:0]  elem_lo_r;        // shadow of select low
	logic [7:0]  elem_hi_r;        // shadow of select high
	sfa_od_t     scl_od_r;         // scl drive
	sfa_od_t     sda_od_r;         // sda drive
	sfa_od_t     sda_dly_r;        // sda drive, one hclk behind scl
	logic        tick;             // half period elapsed

	// count of enabled elements times three, bytes in one sample
	function automatic logic [3:0] sfa_sample_bytes(input logic [7:0] lo,
		input logic [7:0] hi);
		logic [2:0] n;
		n = 3'(lo[3:0] != SFA_ELEM_NONE) + 3'(lo[7:4] != SFA_ELEM_NONE)
			+ 3'(hi[3:0] != SFA_ELEM_NONE) + 3'(hi[7:4] != SFA_ELEM_NONE);
		return 4'(n * SFA_BYTES_PER_ELEM);
	endfunction : sfa_sample_bytes

	// two-flop synchronisers on the pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sda_sync_r <= 2'h3;
			scl_sync_r <= 2'h3;
		end else begin
			sda_sync_r <= {sda_sync_r[0], sda_i};
			scl_sync_r <= {scl_sync_r[0], scl_i};
		end
	end

	assign tick = (div_r == 16'(HALF_CYC - 1));

	// ahb address phase, one-cycle zero-wait slave
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ahb_wr_r  <= 1'b0;
			ahb_rd_r  <= 1'b0;
			ahb_off_r <= 8'h00;
		end else if (hready) begin
			ahb_wr_r  <= hsel && htrans[1] && hwrite;
			ahb_rd_r  <= hsel && htrans[1] && !hwrite;
			ahb_off_r <= haddr[7:0];
		end
	end

	// read data mux registered for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= SFA_ZERO32;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			unique case (haddr[7:0])
				SFA_OFF_CMD:    hrdata <= {15'h0, is_rd_r, reg_r, wdat_r};
				SFA_OFF_STATUS: hrdata <= {28'h0, retry_r == 2'(RETRY_MAX),
					nack_r, done_r, busy_r};
				SFA_OFF_RDATA:  hrdata <= {24'h0, rdat_r};
				SFA_OFF_ELEM:   hrdata <= {28'h0,
					sfa_sample_bytes(elem_lo_r, elem_hi_r)};
				default:        hrdata <= SFA_ZERO32; // unmapped reads zero
			endcase
		end
	end

	// ahb answers are always ready and okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// half-period divider, runs only while busy
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) div_r <= 16'h0;
		else if (!busy_r || tick) div_r <= 16'h0;
		else div_r <= div_r + 16'h1;
	end

	// bit engine and command handling
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r      <= SFA_IDLE;
			ph_r      <= SFA_PH_ADDRW;
			bit_r     <= 4'h0;
			sh_r      <= 8'h00;
			busy_r    <= 1'b0;
			is_rd_r   <= 1'b0;
			reg_r     <= 8'h00;
			wdat_r    <= 8'h00;
			rdat_r    <= 8'h00;
			nack_r    <= 1'b0;
			retry_r   <= 2'h0;
			done_r    <= 1'b0;
			elem_lo_r <= 8'h00;
			elem_hi_r <= 8'h00;
			scl_od_r  <= '0;
			sda_od_r  <= '0;
		end else if (!busy_r) begin
			// idle: both lines released, wait for a command
			scl_od_r <= '0;
			sda_od_r <= '0;
			if (ahb_wr_r && ahb_off_r == SFA_OFF_CMD
				&& hwdata[SFA_CMD_GO_BIT]) begin
				busy_r  <= 1'b1;
				done_r  <= 1'b0;
				nack_r  <= 1'b0;
				retry_r <= 2'h0;
				is_rd_r <= hwdata[SFA_CMD_RD_BIT];
				reg_r   <= hwdata[SFA_CMD_REG_LSB +: 8];
				wdat_r  <= hwdata[SFA_CMD_DATA_LSB +: 8];
				ph_r    <= SFA_PH_ADDRW;
				st_r    <= SFA_START;
			end
		end else if (tick) begin
			unique case (st_r)
				SFA_START: begin
					// sda falls while scl released high
					sda_od_r <= '{o: 1'b0, oe: 1'b1};
					sh_r     <= (ph_r == SFA_PH_ADDRR)
						? {SFA_DEV_ADDR, SFA_DIR_RD}
						: {SFA_DEV_ADDR, SFA_DIR_WR};
					bit_r    <= 4'h0;
					st_r     <= SFA_BITLO;
				end
				SFA_BITLO: begin
					// scl low, then set data bit msb first
					scl_od_r <= '{o: 1'b0, oe: 1'b1};
					if (ph_r == SFA_PH_RDATA)
						sda_od_r <= '0; // release for device
					else
						sda_od_r <= '{o: 1'b0, oe: !sh_r[7]};
					st_r <= SFA_BITHI;
				end
				SFA_BITHI: begin
					// release scl, sample before it goes high
					scl_od_r <= '0;
					sh_r     <= {sh_r[6:0], sda_sync_r[1]};
					bit_r    <= bit_r + 4'h1;
					st_r     <= (bit_r == 4'h7) ? SFA_ACKLO : SFA_BITLO;
				end
				SFA_ACKLO: begin
					// ninth clock: ack from device or master
					scl_od_r <= '{o: 1'b0, oe: 1'b1};
					if (ph_r == SFA_PH_RDATA) begin
						rdat_r   <= sh_r;
						sda_od_r <= '{o: 1'b0, oe: 1'b0}; // nack, single byte
					end else begin
						sda_od_r <= '0;
					end
					st_r <= SFA_ACKHI;
				end
				SFA_ACKHI: begin
					scl_od_r <= '0;
					if (ph_r != SFA_PH_RDATA && sda_sync_r[1])
						nack_r <= 1'b1;
					st_r <= SFA_NEXT;
				end
				SFA_NEXT: begin
					// pull scl low and choose the following byte
					scl_od_r <= '{o: 1'b0, oe: 1'b1};
					bit_r    <= 4'h0;
					if (nack_r || ph_r == SFA_PH_RDATA
						|| ph_r == SFA_PH_WDATA) begin
						sda_od_r <= '{o: 1'b0, oe: 1'b1};
						st_r     <= SFA_STOPL;
					end else if (ph_r == SFA_PH_ADDRW) begin
						ph_r <= SFA_PH_REG;
						sh_r <= reg_r;
						st_r <= SFA_BITLO;
					end else if (ph_r == SFA_PH_ADDRR) begin
						// read address taken, clock in the data byte
						ph_r <= SFA_PH_RDATA;
						st_r <= SFA_BITLO;
					end else if (is_rd_r) begin
						sda_od_r <= '0; // high ahead of restart
						ph_r     <= SFA_PH_ADDRR;
						st_r     <= SFA_RSTRT;
					end else begin
						ph_r <= SFA_PH_WDATA;
						sh_r <= wdat_r;
						st_r <= SFA_BITLO;
					end
				end
				SFA_RSTRT: begin
					// scl released with sda high, start follows
					scl_od_r <= '0;
					st_r     <= SFA_START;
				end
				SFA_STOPL: begin
					scl_od_r <= '0;
					st_r     <= SFA_STOPH;
				end
				SFA_STOPH: begin
					// sda rises while scl high, separate pulse
					sda_od_r <= '0;
					st_r     <= SFA_STOPE;
				end
				SFA_STOPE: begin
					if (nack_r && retry_r != 2'(RETRY_MAX)) begin
						retry_r <= retry_r + 2'h1;
						nack_r  <= 1'b0;
						ph_r    <= SFA_PH_ADDRW;
						st_r    <= SFA_START;
					end else begin
						if (!nack_r && !is_rd_r) begin
							// keep shadow of element selects
							if (reg_r == SFA_REG_ELEM_LO) elem_lo_r <= wdat_r;
							if (reg_r == SFA_REG_ELEM_HI) elem_hi_r <= wdat_r;
						end
						busy_r <= 1'b0;
						done_r <= 1'b1;
						st_r   <= SFA_IDLE;
					end
				end
				default: st_r <= SFA_IDLE;
			endcase
		end
	end

	// pin drives straight from flops, scl low only when driven
	// sda lags scl by one hclk, so data never moves on a clock edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scl_o     <= 1'b0;
			scl_oe    <= 1'b0;
			sda_dly_r <= '0;
			sda_o     <= 1'b0;
			sda_oe    <= 1'b0;
		end else begin
			scl_o     <= scl_od_r.o;
			scl_oe    <= scl_od_r.oe;
			sda_dly_r <= sda_od_r;
			sda_o     <= sda_dly_r.o;
			sda_oe    <= sda_dly_r.oe;
		end
	end
endmodule : sfa_master

//--- src/sfa_pkg.sv
// package for the two-wire master that drives the sensor register port
// assumes a 100 MHz hclk and a device that answers on an open-drain line
package sfa_pkg;
	// bus clock rate and derived half period in hclk cycles
	localparam int SFA_HCLK_KHZ    = 100000;            // system clock
	localparam int SFA_SCL_KHZ     = 400;               // fastest link rate
	localparam int SFA_HALF_CYC    =
		(SFA_HCLK_KHZ + 2 * SFA_SCL_KHZ - 1) / (2 * SFA_SCL_KHZ); // round up
	// device address and direction bit
	localparam logic [6:0] SFA_DEV_ADDR = 7'h5E;        // 0b1011110
	localparam logic       SFA_DIR_WR   = 1'b0;         // master writes
	localparam logic       SFA_DIR_RD   = 1'b1;         // master reads
	// device register offsets
	localparam logic [7:0] SFA_REG_FIFO_DATA = 8'h07;   // non-incrementing
	localparam logic [7:0] SFA_REG_ELEM_LO   = 8'h09;   // first/second select
	localparam logic [7:0] SFA_REG_ELEM_HI   = 8'h0A;   // third/fourth select
	localparam int         SFA_BYTES_PER_ELEM = 3;      // bytes per element
	// element select codes
	localparam logic [3:0] SFA_ELEM_NONE = 4'h0;        // slot unused
	// own register offsets on the ahb side
	localparam logic [7:0] SFA_OFF_CMD    = 8'h00;      // command word
	localparam logic [7:0] SFA_OFF_STATUS = 8'h04;      // status word
	localparam logic [7:0] SFA_OFF_RDATA  = 8'h08;      // last read byte
	localparam logic [7:0] SFA_OFF_ELEM   = 8'h0C;      // sample byte count
	// command word field positions
	localparam int SFA_CMD_DATA_LSB = 0;                // write data byte
	localparam int SFA_CMD_REG_LSB  = 8;                // register address
	localparam int SFA_CMD_RD_BIT   = 16;               // 1 = read
	localparam int SFA_CMD_GO_BIT   = 31;               // start transfer
	// reset values
	localparam logic [31:0] SFA_ZERO32 = 32'h0000_0000; // zero word
	// transfer states, gray in declaration order
	typedef enum logic [3:0] {
		SFA_IDLE  = 4'h0,
		SFA_START = 4'h1,
		SFA_BITLO = 4'h3,
		SFA_BITHI = 4'h2,
		SFA_ACKLO = 4'h6,
		SFA_ACKHI = 4'h7,
		SFA_NEXT  = 4'h5,
		SFA_RSTRT = 4'h4,
		SFA_STOPL = 4'hC,
		SFA_STOPH = 4'hD,
		SFA_STOPE = 4'hF
	} sfa_state_t;
	// phases within one transfer
	typedef enum logic [2:0] {
		SFA_PH_ADDRW = 3'h0,
		SFA_PH_REG   = 3'h1,
		SFA_PH_WDATA = 3'h3,
		SFA_PH_ADDRR = 3'h2,
		SFA_PH_RDATA = 3'h6
	} sfa_phase_t;
	// open-drain pin carrier
	typedef struct packed {
		logic o;   // driven level, always low
		logic oe;  // high while driving low
	} sfa_od_t;
endpackage : sfa_pkg

//--- sim/sfa_master_asserts.sv
// checker: ahb answer, scl timing and open-drain drive of sfa_master
// assumes it is bound to every sfa_master, one clock domain
`timescale 1ns/1ps
module sfa_master_asserts #(
	parameter int HALF_CYC = 4 // scl half period in hclk cycles
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        scl_o,
	input wire logic        scl_oe,
	input wire logic        sda_o,
	input wire logic        sda_oe
);
	import sfa_pkg::*;
	logic [7:0] held_r; // cycles since scl drive changed
	wire logic  rd_a = hsel && hready && htrans == 2'h2 && !hwrite; // read
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// measure how long each scl level stands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			held_r <= 8'h00;
		else if ($changed(scl_oe))
			held_r <= 8'h00;
		else if (held_r != 8'hFF)
			held_r <= held_r + 8'h01;
	end
	sequence s_start; // data pulled low while clock high
		!scl_oe && $rose(sda_oe);
	endsequence
	sequence s_stop; // data released while clock high
		!scl_oe && $fell(sda_oe);
	endsequence
	property p_ahb_ok;
		hreadyout && !hresp;
	endproperty
	a_ahb_ok: assert property (p_ahb_ok)
		else $error("bus answer not ready or not okay");
	property p_scl_od;
		!scl_o;
	endproperty
	a_scl_od: assert property (p_scl_od)
		else $error("scl driven high");
	property p_sda_od;
		!sda_o;
	endproperty
	a_sda_od: assert property (p_sda_od)
		else $error("sda driven high");
	property p_half;
		$changed(scl_oe) |-> held_r >= HALF_CYC - 1;
	endproperty
	a_half: assert property (p_half)
		else $error("scl half period too short");
	property p_start;
		s_start |-> ##[1:1000] $rose(scl_oe);
	endproperty
	a_start: assert property (p_start)
		else $error("no clock after start");
	property p_stop;
		s_stop |=> (!sda_oe && !scl_oe) [*2];
	endproperty
	a_stop: assert property (p_stop)
		else $error("bus not left idle after stop");
	property p_rd_hold;
		!$stable(hrdata) |-> $past(rd_a);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data changed without a read");
	property p_unmapped;
		rd_a && haddr[7:0] > 8'h0C |=> hrdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
endmodule : sfa_master_asserts
bind sfa_master sfa_master_asserts #(.HALF_CYC(HALF_CYC)) u_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .scl_o(scl_o),
	.scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));

//--- sim/sfa_dev_model.sv
// behavioural sensor target on the two wires, registers 0x00-0x0F
// assumes wire levels resolved by the bench with pull-ups
`timescale 1ns/1ps
module sfa_dev_model (
	input  wire logic scl,      // clock wire, input only
	input  wire logic sda,      // data wire level
	input  wire logic nack_en,  // refuse the address byte
	output logic      sda_pull, // pull data low
	output int        n_start   // starts seen
);
	logic [7:0] regs [0:15]; // register bank
	logic [7:0] sh;          // byte shifter
	logic [3:0] ptr;         // register pointer
	logic       act;         // engaged in a transfer
	logic       rd;          // read direction
	int         n;           // clock pulses in byte
	int         ph;          // byte index in frame
	int         fifo_pos;    // byte within the current sample
	logic [4:0] sample_read_index; // whole samples read so far
	initial begin
		sda_pull = 1'b0;
		act = 1'b0;
		rd = 1'b0;
		n_start = 0;
		foreach (regs[i]) regs[i] = 8'h00; // selects reset to zero
		fifo_pos = 0;
		sample_read_index = 5'h00;
	end
	// next fifo port byte: enabled slots only, three bytes each
	task automatic fifo_next(output logic [7:0] b);
		logic [3:0]  c [4]; // slot selects in sample order
		logic [3:0]  s;     // select of the slot being sent
		logic [23:0] w;     // element word
		int          cnt;   // enabled slots
		c = '{regs[9][3:0], regs[9][7:4], regs[10][3:0], regs[10][7:4]};
		cnt = 0;
		s = 4'h0;
		foreach (c[i]) begin
			if (c[i] != 4'h0 && cnt == fifo_pos / 3) s = c[i];
			if (c[i] != 4'h0) cnt++;
		end
		// cardiac zero above bit 17; optical msb at bit 18
		// top optical bits carry the sample index, the bench checks them unmasked
		w = (s == 4'h9) ? 24'h02_0001 : {sample_read_index, 19'h4_0000};
		b = w[23 - 8 * (fifo_pos % 3) -: 8];
		fifo_pos++;
		if (fifo_pos >= 3 * cnt) begin // whole sample read
			fifo_pos = 0;
			sample_read_index++;
		end
	endtask : fifo_next
	// start or repeated start opens a new address byte
	always @(negedge sda) if (scl) begin
		act = 1'b1;
		n = 0;
		ph = 0;
		n_start++;
	end
	// stop ends the transfer anywhere
	always @(posedge sda) if (scl) begin
		act = 1'b0;
		sda_pull = 1'b0;
	end
	// take bits, msb first; nack ends a read
	always @(posedge scl) if (act) begin
		if (!rd || ph == 0) sh = {sh[6:0], sda};
		n++;
		if (rd && ph > 0 && n == 9 && sda) act = 1'b0;
	end
	// drive data and acknowledge while clock low
	always @(negedge scl) if (act) begin
		if (n == 8 && (!rd || ph == 0)) begin // ack byte
			if (ph == 0) rd = sh[0]; // direction bit
			if (ph == 0 && (sh[7:1] != 7'h5E || nack_en)) act = 1'b0;
			else if (ph == 1) ptr = sh[3:0];
			else if (ph > 1) begin
				regs[ptr] = sh;
				if (ptr != 4'h7) ptr++; // fifo port holds
			end
			sda_pull = act;
		end else if (n == 9) begin // release after ack
			sda_pull = 1'b0;
			n = 0;
			if (rd && ph > 0 && ptr != 4'h7) ptr++;
			if (rd && ptr == 4'h7) fifo_next(sh);
			else if (rd) sh = regs[ptr];
			if (rd) sda_pull = !sh[7];
			ph++;
		end else if (rd && ph > 0) // read bits, release at ack
			sda_pull = (n < 8) ? !sh[7 - n] : 1'b0;
	end
endmodule : sfa_dev_model

//--- sim/tb_sfa_master.sv
// self-checking bench: ahb master tasks, sensor model on the wires
// assumes sfa_master with a short scl half period
`timescale 1ns/1ps
module tb_sfa_master;
	import sfa_pkg::*;
	logic        hclk = 1'b0;    // system clock
	logic        hresetn = 1'b0; // reset, active low
	logic        hsel = 1'b0;    // slave select
	logic [31:0] haddr = 32'h0;  // address
	logic [31:0] hwdata = 32'h0; // write data
	logic [1:0]  htrans = 2'h0;  // transfer kind
	logic        hwrite = 1'b0;  // direction
	logic [31:0] hrdata, q;      // read data, last taken
	logic        hreadyout, hresp, scl_oe, sda_oe, pull;
	logic        nack_en = 1'b0; // model refuses address
	wire logic   scl_w = !scl_oe;          // pull-up wire
	wire logic   sda_w = !(sda_oe || pull); // pull-up wire
	int          n_errors = 0, n_compared = 0, n_start, s0;
	always #5 hclk = ~hclk;
	sfa_master #(.HALF_CYC(8)) dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.scl_o(), .scl_oe(scl_oe), .scl_i(scl_w), .sda_o(),
		.sda_oe(sda_oe), .sda_i(sda_w));
	sfa_dev_model u_dev (.scl(scl_w), .sda(sda_w), .nack_en(nack_en),
		.sda_pull(pull), .n_start(n_start));
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] seen, exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// one edge at which hready is seen high, bounded
	task automatic hrdy;
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (k >= 50) begin
			n_errors++;
			end_of_test();
		end
	endtask : hrdy
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		hrdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		hrdy();
		q = hrdata;
	endtask : bus
	// issue a command and poll status until not busy
	task automatic cmd(input logic r, input logic [7:0] ra, d);
		int k;
		bus(1'b1, SFA_OFF_CMD, {1'b1, 14'h0, r, ra, d});
		@(posedge hclk);
		k = 0;
		do begin
			bus(1'b0, SFA_OFF_STATUS, 32'h0);
			k++;
		end while (q[0] !== 1'b0 && k < 600);
		if (k >= 600) begin
			n_errors++;
			end_of_test();
		end
	endtask : cmd
	initial begin
		logic [3:0] codes [5] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h9};
		// sample 0 of two optical and one cardiac, then sample 1 start
		logic [7:0] fifo_exp [10] = '{8'h04, 8'h00, 8'h00, 8'h04, 8'h00,
			8'h00, 8'h02, 8'h00, 8'h01, 8'h0C};
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, SFA_OFF_STATUS, 0);
		chk(q, 32'h0, "status");
		bus(1'b0, SFA_OFF_ELEM, 0);
		chk(q, 32'h0, "count");
		bus(1'b1, 8'h10, 32'hFFFF_FFFF);
		bus(1'b0, 8'h10, 0);
		chk(q, 32'h0, "unmapped");
		$display("test reset done");
		foreach (codes[i]) begin
			cmd(1'b0, SFA_REG_ELEM_LO, {4'h0, codes[i]});
			chk(q[3:0], 4'h2, "status");
			chk(u_dev.regs[9], {4'h0, codes[i]}, "select");
			bus(1'b0, SFA_OFF_ELEM, 0);
			chk(q, 32'd3, "count");
		end
		cmd(1'b0, SFA_REG_ELEM_LO, 8'h21);
		cmd(1'b0, SFA_REG_ELEM_HI, 8'h09);
		chk(u_dev.regs[10], 8'h09, "select");
		bus(1'b0, SFA_OFF_ELEM, 0);
		chk(q, 32'd9, "count");
		$display("test select done");
		cmd(1'b1, SFA_REG_ELEM_HI, 8'h00);
		bus(1'b0, SFA_OFF_RDATA, 0);
		chk(q[7:0], 8'h09, "read byte");
		foreach (fifo_exp[i]) begin
			cmd(1'b1, SFA_REG_FIFO_DATA, 8'h00);
			bus(1'b0, SFA_OFF_RDATA, 0);
			chk(q[7:0], fifo_exp[i], "fifo byte");
		end
		bus(1'b0, SFA_OFF_CMD, 0);
		chk(q, 32'h0001_0700, "command");
		$display("test read done");
		nack_en <= 1'b1;
		s0 = n_start;
		cmd(1'b0, SFA_REG_ELEM_LO, 8'h33);
		chk(q[3:2], 2'h3, "nack status");
		chk(n_start - s0, 4, "attempts");
		chk(u_dev.regs[9], 8'h21, "select");
		nack_en <= 1'b0;
		$display("test nack done");
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, SFA_OFF_ELEM, 0);
		chk(q, 32'h0, "count");
		$display("test second reset done");
		end_of_test();
	end
	initial begin
		repeat (100000) @(posedge hclk);
		n_errors++;
		end_of_test();
	end
endmodule : tb_sfa_master
